// File: verilog/processor_card_core.sv
// processor card core: working registers, return stack, flags,
// vectored interrupts and the backplane address/ready handshake
// assumes one clock, synchronous inputs, memory cards decode the address
`timescale 1ns/1ps
`default_nettype none

module processor_card_core #(
  parameter int levels = processor_card_pkg::levels
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire processor_card_pkg::cmd_t cmd,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rdata,
  output logic [7:0] acc,
  output processor_card_pkg::flags_t flags,
  output logic [13:0] pc,
  output logic [2:0] sp,
  input wire logic [levels-1:0] irq_req,
  input wire logic [levels-1:0] irq_enable,
  input wire logic irq_mask,
  input wire logic rtc_strap,
  input wire logic rtc_req,
  output logic [levels-1:0] irq_ack,
  output logic [13:0] backplane_address_lines,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  output logic bus_rd,
  output logic bus_wr,
  input wire logic ready_n,
  output logic wait_n
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic processor_card_pkg::flags_t result_flags(
    input logic [7:0] r,
    input logic c
  );
    processor_card_pkg::flags_t f;
    f.carry = c;
    f.zero = (r == 8'h00);
    f.sign = r[7];
    f.parity = ~^r;
    return f;
  endfunction : result_flags

  function automatic logic [8:0] alu_calc(
    input processor_card_pkg::alu_op_t op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin
  );
    logic [8:0] r;
    r = 9'h000;
    case (op)
      processor_card_pkg::alu_add: r = {1'b0, a} + {1'b0, b};
      processor_card_pkg::alu_adc: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      processor_card_pkg::alu_sub: r = {1'b0, a} - {1'b0, b};
      processor_card_pkg::alu_sbb: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      processor_card_pkg::alu_cmp: r = {1'b0, a} - {1'b0, b};
      processor_card_pkg::alu_and: r = {1'b0, a & b};
      processor_card_pkg::alu_xor: r = {1'b0, a ^ b};
      default: r = {1'b0, a | b};
    endcase
    return r;
  endfunction : alu_calc

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_addr, st_wait} state_t;

  state_t state;
  state_t next_state;
  logic [7:0] regs [0:processor_card_pkg::reg_count-1];
  logic [13:0] stack [0:processor_card_pkg::stack_depth-1];
  logic guard;
  logic next_guard;
  logic [13:0] next_pc;
  logic [2:0] next_sp;
  logic is_write;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic offer = cmd_valid && cmd_ready;
  wire logic is_mem = (cmd.sel == processor_card_pkg::code_mem);
  wire logic [13:0] mem_ptr = {regs[processor_card_pkg::code_high][5:0],
                               regs[processor_card_pkg::code_low]};
  wire logic [levels-1:0] src;
  wire logic [levels-1:0] pending;
  wire logic any_pending = |pending;
  wire logic [2:0] take_level;
  wire logic take;
  wire logic fire;
  wire logic flag_bit;
  wire logic cond_ok;
  wire logic [8:0] alu_out;
  wire logic [7:0] incdec_out;
  wire logic [13:0] restart_vec;
  wire logic [13:0] irq_vec;
  wire logic [13:0] ret_addr;

  // level seven comes from the clock when strapped
  assign src = {rtc_strap ? rtc_req : irq_req[processor_card_pkg::level_clock],
                irq_req[levels-2:0]};
  // level zero ignores enable and mask
  assign pending = {src[levels-1:1] & irq_enable[levels-1:1] & {(levels-1){~irq_mask}},
                    src[0]};

  // lowest level wins; zero is the catastrophic one
  function automatic logic [2:0] first_set(input logic [levels-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = levels - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 3'(i);
      end
    end
    return n;
  endfunction : first_set

  assign take_level = first_set(pending);
  // taken only at an opcode fetch, and not right after a vector
  assign take = offer && cmd.kind == processor_card_pkg::op_fetch && any_pending && !guard;
  assign fire = offer && !take;
  assign irq_vec = {8'h00, take_level, 3'h0};
  assign restart_vec = {8'h00, cmd.sel, 3'h0};

  assign flag_bit = (cmd.cond_flag == processor_card_pkg::cond_carry) ? flags.carry :
                    (cmd.cond_flag == processor_card_pkg::cond_zero) ? flags.zero :
                    (cmd.cond_flag == processor_card_pkg::cond_sign) ? flags.sign :
                    flags.parity;
  assign cond_ok = !cmd.cond_en || (flag_bit == cmd.cond_sense);

  assign alu_out = alu_calc(cmd.alu, acc, cmd.data, flags.carry);
  assign incdec_out = cmd.dec ? regs[cmd.sel] - 8'h01 : regs[cmd.sel] + 8'h01;
  assign ret_addr = stack[3'(sp + 3'h1)];

  // ------------------------------------------------------------
  // program counter and stack pointer
  // ------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    next_sp = sp;
    next_guard = guard;
    if (take) begin
      next_sp = sp - 3'h1;
      next_pc = irq_vec;
      next_guard = 1'b1;
    end else if (fire) begin
      case (cmd.kind)
        processor_card_pkg::op_fetch: begin
          next_pc = pc + 14'h0001;
          next_guard = 1'b0;
        end
        processor_card_pkg::op_operand: begin
          next_pc = pc + 14'h0001;
        end
        processor_card_pkg::op_jump: begin
          if (cond_ok) begin
            next_pc = cmd.target;
          end
        end
        processor_card_pkg::op_call: begin
          if (cond_ok) begin
            next_sp = sp - 3'h1;
            next_pc = cmd.target;
          end
        end
        processor_card_pkg::op_restart: begin
          next_sp = sp - 3'h1;
          next_pc = restart_vec;
        end
        processor_card_pkg::op_ret: begin
          if (cond_ok) begin
            next_sp = sp + 3'h1;
            next_pc = ret_addr;
          end
        end
        default: begin
          next_pc = pc;
        end
      endcase
    end
  end

  // the active entry always mirrors pc, so the entry below a call
  // still holds the return address; an eighth nested call wraps
  always_ff @(posedge clk) begin
    if (reset) begin
      stack[processor_card_pkg::sp_reset] <= processor_card_pkg::pc_reset;
      pc <= processor_card_pkg::pc_reset;
      sp <= processor_card_pkg::sp_reset;
      guard <= 1'b0;
    end else begin
      stack[next_sp] <= next_pc;
      pc <= next_pc;
      sp <= next_sp;
      guard <= next_guard;
    end
  end

  // ------------------------------------------------------------
  // bus sequencing
  // ------------------------------------------------------------
  wire logic mem_start = fire && (
    cmd.kind == processor_card_pkg::op_fetch ||
    cmd.kind == processor_card_pkg::op_operand ||
    ((cmd.kind == processor_card_pkg::op_load ||
      cmd.kind == processor_card_pkg::op_read) && is_mem));
  // ready counts in the address cycle too, so a fast card skips the wait
  wire logic mem_end = (state != st_idle) && !ready_n;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (mem_start) begin
          next_state = st_addr;
        end
      end
      st_addr: begin
        // ready already low: the wait state is skipped
        next_state = ready_n ? st_wait : st_idle;
      end
      default: begin
        next_state = ready_n ? st_wait : st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_idle;
      cmd_ready <= 1'b0;
      wait_n <= 1'b1;
    end else begin
      state <= next_state;
      cmd_ready <= (next_state == st_idle) && !offer;
      wait_n <= !(next_state == st_wait);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      backplane_address_lines <= processor_card_pkg::pc_reset;
      bus_wdata <= processor_card_pkg::reg_reset;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      is_write <= 1'b0;
    end else if (mem_start) begin
      // only the direction is kept; fetched bytes land in rdata as reads do
      is_write <= cmd.kind == processor_card_pkg::op_load;
      // fetches use pc, data moves use the pointer pair
      backplane_address_lines <= (cmd.kind == processor_card_pkg::op_fetch ||
                                  cmd.kind == processor_card_pkg::op_operand)
                                 ? pc : mem_ptr;
      bus_wdata <= cmd.data;
      bus_rd <= cmd.kind != processor_card_pkg::op_load;
      bus_wr <= cmd.kind == processor_card_pkg::op_load;
    end else if (mem_end) begin
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers, accumulator and flags
  // ------------------------------------------------------------
  wire logic reg_write = fire && cmd.kind == processor_card_pkg::op_load && !is_mem;
  wire logic do_alu = fire && cmd.kind == processor_card_pkg::op_alu;
  wire logic do_incdec = fire && cmd.kind == processor_card_pkg::op_incdec && !is_mem;
  wire logic alu_logic = cmd.alu == processor_card_pkg::alu_and ||
                         cmd.alu == processor_card_pkg::alu_xor ||
                         cmd.alu == processor_card_pkg::alu_or;

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < processor_card_pkg::reg_count; i++) begin
        regs[i] <= processor_card_pkg::reg_reset;
      end
    end else if (reg_write) begin
      regs[cmd.sel] <= cmd.data;
    end else if (do_incdec) begin
      regs[cmd.sel] <= incdec_out;
    end else if (do_alu && cmd.alu != processor_card_pkg::alu_cmp) begin
      regs[processor_card_pkg::code_acc] <= alu_out[7:0];
    end
  end

  // carry kept on loads and on increment or decrement
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= processor_card_pkg::flags_reset;
    end else if (do_alu) begin
      flags <= result_flags(alu_out[7:0], alu_logic ? 1'b0 : alu_out[8]);
    end else if (do_incdec) begin
      flags <= result_flags(incdec_out, flags.carry);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= processor_card_pkg::reg_reset;
    end else if (reg_write && cmd.sel == processor_card_pkg::code_acc) begin
      acc <= cmd.data;
    end else if (do_incdec && cmd.sel == processor_card_pkg::code_acc) begin
      acc <= incdec_out;
    end else if (do_alu && cmd.alu != processor_card_pkg::alu_cmp) begin
      acc <= alu_out[7:0];
    end
  end

  // ------------------------------------------------------------
  // answers and acknowledges
  // ------------------------------------------------------------
  wire logic local_done = fire && !mem_start;

  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      rdata <= processor_card_pkg::reg_reset;
      irq_ack <= '0;
    end else begin
      done <= local_done || mem_end;
      irq_ack <= take ? levels'(1) << take_level : '0;
      if (mem_end && !is_write) begin
        rdata <= bus_rdata;
      end else if (fire && cmd.kind == processor_card_pkg::op_read && !is_mem) begin
        rdata <= regs[cmd.sel];
      end
    end
  end

endmodule : processor_card_core

`default_nettype wire

// File: verilog/processor_card_pkg.sv
// constants, command and flag types for the processor card core
// assumes a sequencer outside issues one decoded step at a time
// Function
// - seven registers, code seven means memory
// - high pointer six bits, low eight
// - pc lives in eight-entry return stack
// - call decrements pointer, target at new entry
// - return increments pointer, resumes there
// - seven nested calls kept, deeper overwrites
// - all four flags updated by ALU ops; inc/dec keep carry
// - carry from arithmetic, cleared by logic
// - zero flag set on zero result
// - sign flag copies result top bit
// - parity flag set on even ones
// - conditional jumps and calls test flags
// - one request input per level
// - level zero unmaskable, others enabled, masked
// - level n vectors to eight times n
// - first vector instruction not interruptible
// - level seven strap to clock request
// - eight acknowledge outputs, one per level
// - fourteen-bit address onto backplane lines
// - wait until ready low, early skips
package processor_card_pkg;

  // ------------------------------------------------------------
  // sizes and codes
  // ------------------------------------------------------------
  localparam int addr_w = 14;
  localparam int data_w = 8;
  localparam int hi_w = 6;
  localparam int stack_depth = 8;
  localparam int levels = 8;
  localparam int reg_count = 7;
  localparam logic [2:0] code_acc = 3'h0;
  localparam logic [2:0] code_high = 3'h5;
  localparam logic [2:0] code_low = 3'h6;
  localparam logic [2:0] code_mem = 3'h7;
  localparam logic [2:0] level_clock = 3'h7;
  localparam int vector_shift = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [13:0] pc_reset = 14'h0000;
  localparam logic [2:0] sp_reset = 3'h0;
  localparam logic [7:0] reg_reset = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none, op_load, op_read, op_alu, op_incdec,
    op_fetch, op_operand, op_jump, op_call, op_ret, op_restart
  } op_kind_t;

  typedef enum logic [2:0] {
    alu_add, alu_adc, alu_sub, alu_sbb, alu_and, alu_xor, alu_or, alu_cmp
  } alu_op_t;

  typedef enum logic [1:0] {
    cond_carry, cond_zero, cond_sign, cond_parity
  } cond_flag_t;

  typedef struct packed {
    op_kind_t kind;
    logic [2:0] sel;
    alu_op_t alu;
    logic dec;
    logic cond_en;
    cond_flag_t cond_flag;
    logic cond_sense;
    logic [7:0] data;
    logic [13:0] target;
  } cmd_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic parity;
  } flags_t;

  localparam flags_t flags_reset = '{carry: 1'b0, zero: 1'b0, sign: 1'b0, parity: 1'b0};

endpackage : processor_card_pkg

// File: verification/processor_card_core_asserts.sv
// assertions on the processor card core ports
// assumes one clock domain; bound onto every core instance
`timescale 1ns/1ps
`default_nettype none
module processor_card_core_asserts #(
  parameter int levels = processor_card_pkg::levels
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire processor_card_pkg::cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic [7:0] acc,
  input wire processor_card_pkg::flags_t flags,
  input wire logic [13:0] pc,
  input wire logic [2:0] sp,
  input wire logic [levels-1:0] irq_req,
  input wire logic irq_mask,
  input wire logic [levels-1:0] irq_ack,
  input wire logic [13:0] backplane_address_lines,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic ready_n,
  input wire logic wait_n
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic mem_cyc = bus_rd || bus_wr;
  wire logic any_ack = |irq_ack;
  // memory operands excluded: their answer comes later
  sequence s_take(processor_card_pkg::op_kind_t k);
    cmd_valid && cmd_ready && cmd.kind == k && cmd.sel != 3'h7;
  endsequence
  sequence s_alu_logic;
    s_take(processor_card_pkg::op_alu) ##0
      cmd.alu inside {processor_card_pkg::alu_and, processor_card_pkg::alu_xor,
      processor_card_pkg::alu_or};
  endsequence
  property p_ack_onehot; any_ack |-> $onehot(irq_ack); endproperty
  a_ack_onehot: assert property (p_ack_onehot) else $error("ack not one-hot");
  property p_vector; any_ack |-> pc == {8'h00, pc[5:3], 3'h0} && irq_ack[pc[5:3]]; endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_push; any_ack |-> sp == 3'($past(sp) - 3'h1); endproperty
  a_push: assert property (p_push) else $error("no push on interrupt");
  property p_mask; |irq_ack[levels-1:1] |-> !$past(irq_mask); endproperty
  a_mask: assert property (p_mask) else $error("masked level taken");
  property p_req0; irq_ack[0] |-> $past(irq_req[0]); endproperty
  a_req0: assert property (p_req0) else $error("level zero without request");
  property p_ready; mem_cyc && !ready_n |=> !mem_cyc && done && wait_n; endproperty
  a_ready: assert property (p_ready) else $error("ready not honoured");
  property p_wait; mem_cyc && ready_n |=> !wait_n && mem_cyc; endproperty
  a_wait: assert property (p_wait) else $error("no wait state");
  property p_addr; $past(mem_cyc) && mem_cyc |-> $stable(backplane_address_lines); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_logic; s_alu_logic |=> !flags.carry; endproperty
  a_logic: assert property (p_logic) else $error("carry kept by logic op");
  property p_incdec;
    s_take(processor_card_pkg::op_incdec) |=> flags.carry == $past(flags.carry);
  endproperty
  a_incdec: assert property (p_incdec) else $error("carry changed");
  property p_result;
    s_take(processor_card_pkg::op_alu) ##0 cmd.alu != processor_card_pkg::alu_cmp |=>
      flags.zero == (acc == 8'h00) && flags.sign == acc[7] && flags.parity == ~^acc;
  endproperty
  a_result: assert property (p_result) else $error("flags off result");
  property p_call;
    s_take(processor_card_pkg::op_call) ##0 !cmd.cond_en |=>
      sp == 3'($past(sp) - 3'h1) && pc == $past(cmd.target);
  endproperty
  a_call: assert property (p_call) else $error("call stack wrong");
  property p_ret;
    s_take(processor_card_pkg::op_ret) ##0 !cmd.cond_en |=> sp == 3'($past(sp) + 3'h1);
  endproperty
  a_ret: assert property (p_ret) else $error("return pointer wrong");
endmodule : processor_card_core_asserts
bind processor_card_core processor_card_core_asserts #(.levels(levels))
  processor_card_core_asserts_i (.clk, .reset, .cmd_valid, .cmd, .cmd_ready, .done, .acc,
  .flags, .pc, .sp, .irq_req, .irq_mask, .irq_ack, .backplane_address_lines, .bus_rd,
  .bus_wr, .ready_n, .wait_n);
`default_nettype wire

// File: verification/backplane_memory.sv
// behavioural 2 K memory card on the backplane address lines
// assumes the core holds its strobes until it has seen ready low
`timescale 1ns/1ps
`default_nettype none
module backplane_memory #(
  parameter logic [2:0] card_sel = 3'h0
) (
  input wire logic clk,
  input wire logic [13:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rd,
  input wire logic wr,
  input wire logic [3:0] delay,
  output logic [7:0] rdata,
  output logic ready_n
);
  // ----
  // card
  // ----
  logic [7:0] mem [0:2047];
  logic [7:0] last = 8'h00;
  logic [3:0] cnt = 4'h0;
  // other cards stay silent, so a stray address hangs the core
  wire logic hit = (rd || wr) && addr[13:11] == card_sel;
  assign ready_n = !(hit && cnt >= delay);
  // no stale data once released
  assign rdata = (rd && !ready_n) ? mem[addr[10:0]] : ~last;
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i * 3);
    end
  end
  always @(posedge clk) begin
    cnt <= hit ? cnt + 4'h1 : 4'h0;
    if (rd && !ready_n) last <= rdata;
    if (wr && !ready_n) mem[addr[10:0]] <= wdata;
  end
endmodule : backplane_memory
`default_nettype wire

// File: verification/processor_card_core_bench.sv
// self-checking bench for the processor card core
// assumes every fetch and data address falls on memory card zero
`timescale 1ns/1ps
`default_nettype none
module processor_card_core_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  processor_card_pkg::cmd_t cmd = '0;
  logic cmd_ready, done, bus_rd, bus_wr, ready_n, wait_n, saw_wait;
  logic [7:0] rdata, acc, bus_wdata, bus_rdata, irq_ack, seen_ack;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_enable = 8'h00;
  logic irq_mask = 1'b0;
  logic rtc_strap = 1'b0;
  logic rtc_req = 1'b0;
  logic [3:0] delay = 4'h0;
  processor_card_pkg::flags_t flags;
  logic [13:0] pc, addr, seen_addr, seen_pc;
  logic [2:0] sp;
  int n_errors = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  processor_card_core processor_card_core_i (.clk, .reset, .cmd_valid, .cmd, .cmd_ready,
    .done, .rdata, .acc, .flags, .pc, .sp, .irq_req, .irq_enable, .irq_mask, .rtc_strap,
    .rtc_req, .irq_ack, .backplane_address_lines(addr), .bus_wdata, .bus_rdata, .bus_rd,
    .bus_wr, .ready_n, .wait_n);
  backplane_memory backplane_memory_i (.clk, .addr, .wdata(bus_wdata), .rdata(bus_rdata),
    .rd(bus_rd), .wr(bus_wr), .delay, .ready_n);
  // ----
  // helpers
  // ----
  task automatic complete_run;
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic processor_card_pkg::cmd_t mk(input processor_card_pkg::op_kind_t k,
      input logic [2:0] s, input logic [7:0] d, input logic [13:0] t);
    mk = '0;
    mk.kind = k;
    mk.sel = s;
    mk.data = d;
    mk.target = t;
  endfunction : mk
  // an accepted interrupt leaves the fetch offered for a retry
  task automatic run(input processor_card_pkg::cmd_t c);
    logic taken;
    taken = 1'b0;
    seen_ack = 8'h00;
    saw_wait = 1'b0;
    while (!taken) begin
      @(negedge clk);
      if (cmd_ready === 1'b1) begin
        cmd_valid = 1'b1;
        cmd = c;
        @(negedge clk);
        if (irq_ack === 8'h00) taken = 1'b1;
        else begin
          seen_ack = irq_ack;
          seen_pc = pc;
        end
      end
    end
    cmd_valid = 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) begin
      if (bus_rd || bus_wr) seen_addr = addr;
      if (wait_n === 1'b0) saw_wait = 1'b1;
      @(negedge clk);
    end
    chk(14'(done), 14'h0001);
  endtask : run
  task automatic ld(input logic [2:0] s, input logic [7:0] d);
    run(mk(processor_card_pkg::op_load, s, d, 14'h0000));
  endtask : ld
  task automatic rd(input logic [2:0] s);
    run(mk(processor_card_pkg::op_read, s, 8'h00, 14'h0000));
  endtask : rd
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    for (int r = 0; r < 7; r++) ld(3'(r), 8'(8'h11 * (r + 1)));
    for (int r = 0; r < 7; r++) begin
      rd(3'(r));
      chk(14'(rdata), 14'(8'(8'h11 * (r + 1))));
    end
    ld(3'h5, 8'h02);
    ld(3'h6, 8'h9c);
    ld(3'h7, 8'h5a);
    chk(seen_addr, 14'h029c);
    chk(14'(seen_addr[13:9]), 14'h0001);
    delay = 4'h3;
    rd(3'h7);
    chk(14'(rdata), 14'h005a);
    chk(14'(saw_wait), 14'h0001);
    ld(3'h6, 8'h10);
    rd(3'h7);
    chk(14'(rdata), 14'h0030);
    run(mk(processor_card_pkg::op_jump, 3'h0, 8'h00, 14'h0040));
    run(mk(processor_card_pkg::op_operand, 3'h0, 8'h00, 14'h0000));
    chk(14'(rdata), 14'h00c0);
    chk(pc, 14'h0041);
    run(mk(processor_card_pkg::op_none, 3'h0, 8'h00, 14'h0000));
    chk(pc, 14'h0041);
    delay = 4'h0;
  endtask : t_regs
  task automatic t_alu;
    processor_card_pkg::cmd_t c;
    logic [7:0] av [3];
    logic [8:0] r, a;
    logic cy;
    av = '{8'hc5, 8'h6b, 8'h2a};
    cy = flags.carry;
    ld(3'h1, 8'h6b);
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 8; k++) begin
        a = {1'b0, av[j]};
        ld(3'h0, av[j]);
        c = mk(processor_card_pkg::op_alu, 3'h1, 8'h6b, 14'h0000);
        c.alu = processor_card_pkg::alu_op_t'(3'(k));
        run(c);
        case (k)
          0: r = a + 9'h06b;
          1: r = a + 9'h06b + 9'(cy);
          2, 7: r = a - 9'h06b;
          3: r = a - 9'h06b - 9'(cy);
          4: r = a & 9'h06b;
          5: r = a ^ 9'h06b;
          default: r = a | 9'h06b;
        endcase
        cy = r[8];
        chk(14'(acc), k == 7 ? 14'(a[7:0]) : 14'(r[7:0]));
        chk(14'(flags), 14'({r[8], r[7:0] == 8'h00, r[7], ~^r[7:0]}));
      end
    end
    ld(3'h1, 8'hff);
    c = mk(processor_card_pkg::op_incdec, 3'h1, 8'h00, 14'h0000);
    run(c);
    chk(14'(flags), 14'({cy, 3'b101}));
    c.dec = 1'b1;
    run(c);
    chk(14'(flags), 14'({cy, 3'b011}));
  endtask : t_alu
  task automatic t_stack;
    processor_card_pkg::cmd_t c;
    logic [2:0] s0;
    logic [3:0] fv;
    // depth eight wraps onto the main entry
    for (int d = 7; d < 9; d++) begin
      run(mk(processor_card_pkg::op_jump, 3'h0, 8'h00, 14'h0100));
      s0 = sp;
      for (int k = 1; k <= d; k++) run(mk(processor_card_pkg::op_call, 3'h0, 8'h00,
        14'(14'h0100 + 16 * k)));
      chk(14'(sp), 14'(3'(s0 - 3'(d))));
      for (int k = d - 1; k >= 0; k--) begin
        run(mk(processor_card_pkg::op_ret, 3'h0, 8'h00, 14'h0000));
        chk(pc, (k == 0 && d == 7) ? 14'h0100 : 14'(14'h0100 + 16 * (k == 0 ? 8 : k)));
      end
    end
    ld(3'h0, 8'h00);
    c = mk(processor_card_pkg::op_alu, 3'h0, 8'h00, 14'h0000);
    c.alu = processor_card_pkg::alu_or;
    run(c);
    fv = 4'b1010;
    for (int i = 0; i < 8; i++) begin
      c = mk(processor_card_pkg::op_jump, 3'h0, 8'h00, 14'(14'h0200 + i));
      c.cond_en = 1'b1;
      c.cond_flag = processor_card_pkg::cond_flag_t'(2'(i / 2));
      c.cond_sense = i[0];
      run(c);
      chk(14'(pc === c.target), 14'(fv[i / 2] == i[0]));
    end
    s0 = sp;
    run(mk(processor_card_pkg::op_restart, 3'h3, 8'h00, 14'h0000));
    chk(pc, 14'h0018);
    chk(14'(sp), 14'(3'(s0 - 3'h1)));
  endtask : t_stack
  task automatic t_irq;
    irq_enable = 8'hff;
    rtc_strap = 1'b1;
    // level six stays pending for levels zero to six to test priority and the guard
    for (int n = 0; n < 8; n++) begin
      run(mk(processor_card_pkg::op_jump, 3'h0, 8'h00, 14'h0123));
      irq_req = (n < 7) ? 8'(8'h01 << n) | 8'h40 : 8'h00;
      rtc_req = (n == 7);
      run(mk(processor_card_pkg::op_fetch, 3'h0, 8'h00, 14'h0000));
      chk(14'(seen_ack), 14'(8'(8'h01 << n)));
      chk(seen_pc, 14'(8 * n));
      irq_req = 8'h00;
      rtc_req = 1'b0;
      run(mk(processor_card_pkg::op_ret, 3'h0, 8'h00, 14'h0000));
      chk(pc, 14'h0123);
    end
    irq_mask = 1'b1;
    for (int i = 0; i < 3; i++) begin
      irq_req = (i == 1) ? 8'h01 : 8'h02;
      if (i == 2) irq_mask = 1'b0;
      if (i == 2) irq_enable = 8'hfd;
      run(mk(processor_card_pkg::op_fetch, 3'h0, 8'h00, 14'h0000));
      chk(14'(seen_ack), 14'(i == 1));
      irq_req = 8'h00;
    end
  endtask : t_irq
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_alu();
    t_stack();
    t_irq();
    complete_run();
  end
  initial begin
    #40000;
    n_errors++;
    complete_run();
  end
endmodule : processor_card_core_bench
`default_nettype wire
